// ==== hw/flow_through_burst_sram_port.sv ====
/*
  device side of a flow-through burst static memory: input registers,
  burst counter, byte-lane writes, bidirectional data and parity lanes.
  assumes pins arrive on core_clk_in's domain via the host's own clocked logic;
  output enable is asynchronous and gates drivers combinationally.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_defines.svh"
// How it works
// - all synchronous inputs registered on rising edge
// - input data captured on rising edge
// - read drives word addressed at previous edge
// - lanes drive only while output enable low
// - float on write data, post-deselect, deselected
// - parity lanes behave exactly like data lanes
// - strap low linear, high interleaved order
// - qualifier high freezes all internal state except the strap capture
// - access starts only with all selects active
// - load low when selected latches address
// - write strobe low means write access
// - only masked-in byte lanes are written
// - write completes self-timed, no extra strobes
// - one operation per qualified cycle, no waits
// - advance high steps two-bit burst counter
// - selected when first, third low, second high
// - four-beat bursts, low address bits wrap
// - write data taken at the following edge
module flow_through_burst_sram_port
  import sram_port_pkg::*;
#(
  parameter int BYTES      = `DATA_BYTES_DEFAULT,
  parameter int ADDR_WIDTH = `ADDR_WIDTH_DEFAULT
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    clock_qualifier_n_in,
  input  wire logic                    chip_select_first_n_in,
  input  wire logic                    chip_select_second_in,
  input  wire logic                    chip_select_third_n_in,
  input  wire logic                    advance_or_load_in,
  input  wire logic                    write_enable_n_in,
  input  wire logic [BYTES-1:0]        byte_lane_mask_n_in,
  input  wire logic [ADDR_WIDTH-1:0]   addr_in,
  input  wire logic                    output_enable_n_in,
  input  wire logic                    burst_order_in,
  input  wire logic [8*BYTES-1:0]      data_lanes_in,
  input  wire logic [BYTES-1:0]        parity_lanes_in,
  output logic      [8*BYTES-1:0]      data_lanes_out,
  output logic      [BYTES-1:0]        parity_lanes_out,
  output logic                         lanes_oe_out
);
  localparam int WORDS = 1 << ADDR_WIDTH;
  localparam int LANE  = 9;

  initial begin
    if (BYTES != 4 || ADDR_WIDTH < `BURST_BITS) begin
      $error("unsupported port geometry");
    end
  end

  // storage: each byte carries its parity bit alongside
  logic [LANE*BYTES-1:0]   mem [WORDS];
  port_state_type          state;
  logic [ADDR_WIDTH-1:0]   base_addr;
  logic [1:0]              beat;
  logic                    access_write;
  logic                    order_interleaved;
  logic                    order_taken;
  logic [BYTES-1:0]        wr_mask_n;
  logic [ADDR_WIDTH-1:0]   wr_addr;
  logic [8*BYTES-1:0]      rd_data;
  logic [BYTES-1:0]        rd_par;

  wire                     qualified;
  wire                     selected;
  wire                     load_op;
  wire                     adv_op;
  wire                     start_op;
  wire                     deselect_op;
  wire [1:0]               low_addr;
  wire [1:0]               next_low_addr;
  wire [1:0]               next_beat;
  wire [ADDR_WIDTH-1:0]    cur_addr;
  wire [ADDR_WIDTH-1:0]    next_addr;
  wire                     active;
  wire [LANE*BYTES-1:0]    write_word;
  wire [LANE*BYTES-1:0]    read_word;
  port_state_type          next_state;

  assign qualified   = !clock_qualifier_n_in;
  assign selected    = !chip_select_first_n_in && chip_select_second_in
                       && !chip_select_third_n_in;
  assign load_op     = qualified && !advance_or_load_in;
  assign start_op    = load_op && selected;
  assign deselect_op = load_op && !selected;
  // advance steps only a burst already in flight
  assign adv_op      = qualified && advance_or_load_in && (state != st_idle);
  assign next_beat   = 2'(beat + `BURST_ONE);
  assign active      = start_op || adv_op;
  assign cur_addr    = {base_addr[ADDR_WIDTH-1:`BURST_BITS], low_addr};
  assign next_addr   = start_op ? addr_in
                                : {base_addr[ADDR_WIDTH-1:`BURST_BITS], next_low_addr};

  burst_stepper u_cur (
    .order_interleaved_in (order_interleaved),
    .start_in             (base_addr[1:0]),
    .beat_in              (beat),
    .low_addr_out         (low_addr)
  );

  burst_stepper u_next (
    .order_interleaved_in (order_interleaved),
    .start_in             (base_addr[1:0]),
    .beat_in              (next_beat),
    .low_addr_out         (next_low_addr)
  );

  // type is latched at burst start and kept through the burst
  assign next_state = deselect_op ? st_idle
                    : start_op    ? (write_enable_n_in ? st_read : st_write)
                    : state;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state        <= st_idle;
      base_addr    <= '0;
      beat         <= `BURST_ZERO;
      access_write <= `ACCESS_READ;
      wr_mask_n    <= '1;
      wr_addr      <= '0;
    end else if (qualified) begin
      state <= next_state;
      if (start_op) begin
        base_addr    <= addr_in;
        beat         <= `BURST_ZERO;
        access_write <= !write_enable_n_in;
      end else if (adv_op) begin
        beat <= next_beat;
      end
      wr_mask_n <= byte_lane_mask_n_in;
      wr_addr   <= start_op ? addr_in : next_addr;
    end
  end

  // strap caught by a clocked process after reset release
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      order_taken       <= 1'b0;
      order_interleaved <= `ORDER_LINEAR;
    end else if (!order_taken) begin
      order_taken       <= 1'b1;
      order_interleaved <= burst_order_in;
    end
  end

  genvar b;
  generate
    for (b = 0; b < BYTES; b++) begin : g_lane
      assign write_word[LANE*b +: LANE] = {parity_lanes_in[b], data_lanes_in[8*b +: 8]};
    end
  endgenerate

  // the write address/mask were registered at the previous qualified edge; data comes
  // on the next qualified edge and the array update is self-timed
  logic active_prev;
  wire  write_phase;
  assign write_phase = (state == st_write) && active_prev;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_prev <= 1'b0;
    end else if (qualified) begin
      active_prev <= active && (next_state != st_idle);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (qualified && write_phase) begin
      for (int i = 0; i < BYTES; i++) begin
        if (!wr_mask_n[i]) begin
          mem[cur_addr][LANE*i +: LANE] <= write_word[LANE*i +: LANE];
        end
      end
    end
  end

  // flow-through: read word follows the address registered last edge
  assign read_word = mem[cur_addr];
  always_comb begin
    for (int i = 0; i < BYTES; i++) begin
      rd_data[8*i +: 8] = read_word[LANE*i +: 8];
      rd_par[i]         = read_word[LANE*i + 8];
    end
  end
  assign data_lanes_out   = rd_data;
  assign parity_lanes_out = rd_par;

  // state == read covers deselect and the first clock out of it; write
  // phase is masked regardless of output enable
  assign lanes_oe_out = !output_enable_n_in && (state == st_read) && active_prev;

  // wr_addr is kept for visibility of the pipelined write target
  wire unused_ok;
  assign unused_ok = ^wr_addr || access_write;

  property p_start_latch;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      start_op |=> base_addr == $past(addr_in);
  endproperty
  a_start_latch: assert property (p_start_latch) else $error("address not latched");

  property p_freeze;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      !qualified |=> $stable(state) && $stable(beat) && $stable(base_addr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while unqualified");

  property p_no_drive_write;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      state == st_write |-> !lanes_oe_out;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("drove during write");

  property p_oe_gate;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      output_enable_n_in |-> !lanes_oe_out;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drove with enable high");

  property p_kind;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      start_op |=> (state == st_write) == !$past(write_enable_n_in);
  endproperty
  a_kind: assert property (p_kind) else $error("wrong access kind");

  property p_step;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      adv_op && !start_op |=> beat == 2'($past(beat) + `BURST_ONE);
  endproperty
  a_step: assert property (p_step) else $error("burst counter did not step");

  property p_deselect;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      deselect_op |=> state == st_idle && !lanes_oe_out;
  endproperty
  a_deselect: assert property (p_deselect) else $error("not idle after deselect");

  property p_select_needed;
    @(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(state != st_idle) |-> $past(selected) && $past(qualified);
  endproperty
  a_select_needed: assert property (p_select_needed) else $error("started unselected");
endmodule
`default_nettype wire

// ==== hw/sram_port_defines.svh ====
/*
  constant names for the flow-through burst memory port: widths, burst
  encodings and reset values.
  assumes it is included by bare name from hw/ sources.
*/
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH
`define DATA_BYTES_DEFAULT   4
`define ADDR_WIDTH_DEFAULT   8
`define BURST_BITS           2
`define BURST_ZERO           2'h0
`define BURST_ONE            2'h1
`define BURST_LAST           2'h3
`define ORDER_LINEAR         1'h0
`define ACCESS_READ          1'h0
`define ACCESS_WRITE         1'h1
`endif

// ==== hw/sram_port_pkg.sv ====
/*
  types shared by the memory port and its burst address stepper.
  assumes sram_port_defines.svh is available on the include path.
*/
package sram_port_pkg;
  typedef enum logic [1:0] {
    st_idle  = 2'b00,
    st_read  = 2'b01,
    st_write = 2'b10
  } port_state_type;

  typedef struct packed {
    logic       sel;
    logic       load;
    logic       write_n;
    logic [3:0] mask_n;
  } ctrl_sample_type;
endpackage

// ==== hw/burst_stepper.sv ====
/*
  two-bit burst address generator, linear or interleaved.
  assumes start and beat come from registers on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_defines.svh"
module burst_stepper
  import sram_port_pkg::*;
(
  input  wire logic       order_interleaved_in,
  input  wire logic [1:0] start_in,
  input  wire logic [1:0] beat_in,
  output logic      [1:0] low_addr_out
);
  wire [1:0] linear_addr;
  wire [1:0] interleaved_addr;
  // linear wraps modulo four, interleaved xors start with beat
  assign linear_addr      = 2'(start_in + beat_in);
  assign interleaved_addr = start_in ^ beat_in;
  assign low_addr_out     = order_interleaved_in ? interleaved_addr : linear_addr;
endmodule
`default_nettype wire

// ==== verification/host_lane_model.sv ====
/*
  host side of the shared data and parity lanes: resolves the wire level.
  assumes the bench says when the host drives and with what word.
*/
`timescale 1ns/10ps
`default_nettype none
module host_lane_model (
  input  wire logic        core_clk_in,
  input  wire logic        drive_in,
  input  wire logic [35:0] data_in,
  input  wire logic [35:0] dev_data_in,
  input  wire logic        dev_oe_in,
  output logic      [35:0] lanes_out
);
  logic [35:0] last = 36'h0;
  // a floating wire flips every cycle so a stale word can never pass for fresh data
  assign lanes_out = dev_oe_in ? dev_data_in : drive_in ? data_in : ~last;
  always_ff @(posedge core_clk_in) begin
    last <= lanes_out;
  end
endmodule
`default_nettype wire

// ==== verification/flow_through_burst_sram_port_tb.sv ====
/*
  bench for the burst memory port: random bursts in both orders, byte masks,
  stalls, every select pattern and write-to-read turnaround.
  assumes the hw/ header, package and design are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module flow_through_burst_sram_port_tb;
  import sram_port_pkg::*;
  logic        core_clk_in = 0;
  logic        rst_n_in = 0;
  logic        qn = 0, adv = 0, we_n = 1, oe_n = 0, order = 0, drv = 0;
  logic [2:0]  cs = 3'h5;
  logic [3:0]  m_n = 4'hf;
  logic [7:0]  a = 8'h00, s;
  logic [35:0] hd = 36'h0, d, wire_lanes, exp_mem [256];
  logic [31:0] dout;
  logic [3:0]  pout;
  logic        oe;
  int          failures = 0, tests_run = 0, seed = 12526;
  always #5 core_clk_in = ~core_clk_in;
  flow_through_burst_sram_port u_flow_through_burst_sram_port (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .clock_qualifier_n_in(qn),
    .chip_select_first_n_in(cs[2]), .chip_select_second_in(cs[1]), .chip_select_third_n_in(cs[0]),
    .advance_or_load_in(adv), .write_enable_n_in(we_n), .byte_lane_mask_n_in(m_n), .addr_in(a),
    .output_enable_n_in(oe_n), .burst_order_in(order), .data_lanes_in(wire_lanes[31:0]),
    .parity_lanes_in(wire_lanes[35:32]), .data_lanes_out(dout), .parity_lanes_out(pout),
    .lanes_oe_out(oe));
  host_lane_model u_host_lane_model (.core_clk_in(core_clk_in), .drive_in(drv), .data_in(hd),
    .dev_data_in({pout, dout}), .dev_oe_in(oe), .lanes_out(wire_lanes));
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // inputs change at a rising edge and are taken at the next one
  task automatic op(input logic q, input logic [2:0] c, input logic ad, input logic w,
                    input logic [7:0] ar, input logic [35:0] dd, input logic [3:0] m, input logic dr);
    @(posedge core_clk_in);
    {qn, cs, adv, we_n, a, hd, m_n, drv} <= {q, c, ad, w, ar, dd, m, dr};
  endtask
  function automatic logic [7:0] baddr(input logic [7:0] st, input logic [1:0] b);
    baddr = {st[7:2], order ? st[1:0] ^ b : st[1:0] + b};
  endfunction
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] dd, input logic [3:0] m);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) begin
        merge[8*i+:8] = dd[8*i+:8];
        merge[32+i] = dd[32+i];
      end
    end
  endfunction
  task automatic wburst(input logic full);
    logic [35:0] dq [4];
    logic [3:0]  mq [5];
    // a beat's mask rides on the edge before its data: the command edge first
    for (int b = 0; b < 4; b++) begin
      dq[b] = 36'({$random(seed), $random(seed)});
      mq[b] = full ? 4'h0 : 4'($random(seed));
      exp_mem[baddr(s, 2'(b))] = merge(exp_mem[baddr(s, 2'(b))], dq[b], mq[b]);
    end
    mq[4] = 4'hf;
    op(0, 3'h2, 0, 0, s, 36'h0, mq[0], 0);
    for (int b = 0; b < 4; b++) begin
      op(0, b == 3 ? 3'h5 : 3'h2, b != 3, 1, s, dq[b], mq[b + 1], 1);
    end
  endtask
  task automatic rburst(input logic o);
    oe_n <= o;
    op(0, 3'h2, 0, 1, s, 36'h0, 4'hf, 0);
    // step 1 is a stalled edge, so beat 1 must still show after it
    for (int k = 0; k < 5; k++) begin
      op(k == 1, k == 4 ? 3'h5 : 3'h2, k != 4, 1, s, 36'h0, 4'hf, 0);
      #1;
      check({pout, dout}, exp_mem[baddr(s, 2'(k - (k > 1)))]);
      check({35'h0, oe}, {35'h0, !o});
    end
    op(0, 3'h5, 0, 1, s, 36'h0, 4'hf, 0);
    #1;
    check({35'h0, oe}, 36'h0);
    oe_n <= 0;
  endtask
  initial begin
    for (int r = 0; r < 2; r++) begin
      rst_n_in <= 0;
      order <= r[0];
      repeat (10) @(posedge core_clk_in);
      rst_n_in <= 1;
      repeat (2) @(posedge core_clk_in);
      for (int i = 0; i < 6; i++) begin
        s = i == 0 ? 8'hff : 8'($random(seed));
        wburst(1);
        wburst(0);
        // no pattern but the one full select may start a write
        for (int c = 0; c < 8; c++) begin
          if (c != 2) begin
            op(0, 3'(c), 0, 0, s, 36'h0, 4'h0, 0);
            op(0, 3'h5, 0, 1, s, 36'({$random(seed), $random(seed)}), 4'h0, 1);
          end
        end
        rburst(i[0]);
        d = 36'({$random(seed), $random(seed)});
        exp_mem[s] = d;
        op(0, 3'h2, 0, 0, s, 36'h0, 4'h0, 0);
        op(0, 3'h2, 0, 1, s, d, 4'hf, 1);
        op(0, 3'h5, 0, 1, s, 36'h0, 4'hf, 0);
        #1;
        check({pout, dout}, d);
      end
    end
    final_report;
  end
  initial begin
    #100000;
    failures++;
    final_report;
  end
endmodule
`default_nettype wire
